//--- hw/sbsd_pkg.sv
// Shared constants and types of the slot bus slave decoder.
package sbsd_pkg;
	// Clock periods in ns and the longest host cycle, in bus clocks and in clocks.
	localparam int CLK_PERIOD_NS  = 40;
	localparam int BUS_PERIOD_NS  = 100;
	localparam int MAX_BUS_CLOCKS = 5;
	localparam int MAX_CYC_INT    = (MAX_BUS_CLOCKS * BUS_PERIOD_NS) / CLK_PERIOD_NS;
	localparam logic [3:0] MAX_CYCLES = MAX_CYC_INT[3:0];
	localparam logic [3:0] CNT_ZERO   = 4'h0;
	localparam logic [3:0] CNT_ONE    = 4'h1;

	// Local access length in clocks.
	localparam logic [1:0] LOC_WAIT = 2'h2;
	localparam logic [1:0] ACC_ZERO = 2'h0;
	localparam logic [1:0] ACC_ONE  = 2'h1;

	// Address fields.
	localparam int SLOT_HI = 31;
	localparam int SLOT_LO = 24;
	localparam int DEV_HI  = 19;
	localparam int DEV_LO  = 18;
	localparam int LOC_HI  = 15;
	localparam int LOC_LO  = 2;
	localparam int LOC_W   = LOC_HI - LOC_LO + 1;
	localparam int ID_W    = 4;
	localparam int SYNC_W  = 2 + 2 + 32 + ID_W;
	localparam logic [3:0] SUPER_SLOT = 4'hF;

	// Device regions selected by the two device bits.
	localparam logic [1:0] REGION_NONE = 2'h0;
	localparam logic [1:0] REGION_RAM  = 2'h1;
	localparam logic [1:0] REGION_PC   = 2'h2;
	localparam logic [1:0] REGION_ROM  = 2'h3;

	// Status codes, bit 0 is mode line 0.
	localparam logic [1:0] TM_COMPLETE = 2'h3;
	localparam logic [1:0] TM_BUSERR   = 2'h2;
	localparam logic [1:0] TM_IDLE     = 2'h0;

	// Byte lanes of the 16-bit RAM word.
	localparam logic [1:0] LANE_NONE = 2'h0;
	localparam logic [1:0] LANE_B0   = 2'h1;
	localparam logic [1:0] LANE_B1   = 2'h2;
	localparam logic [1:0] LANE_BOTH = 2'h3;

	typedef enum logic [2:0] {
		kind_ram_rd,
		kind_ram_wr,
		kind_rom_rd,
		kind_pc_rd,
		kind_pc_wr,
		kind_err
	} sbsd_kind_e;
endpackage

//--- hw/sbsd_sync.sv
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/1ps
module sbsd_sync #(
	parameter int W = 1
) (
	// Clock and reset.
	input  wire logic         clock_in,
	input  wire logic         rst_n_in,
	input  wire logic         ce_in,
	// Raw and filtered levels.
	input  wire logic [W-1:0] raw_in,
	output logic      [W-1:0] level_out
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge clock_in or negedge rst_n_in) begin
			if (!rst_n_in) begin
				s1_q[i]      <= 1'b0;
				s2_q[i]      <= 1'b0;
				s3_q[i]      <= 1'b0;
				level_out[i] <= 1'b0;
			end else if (ce_in) begin
				s1_q[i] <= raw_in[i];
				s2_q[i] <= s1_q[i];
				s3_q[i] <= s2_q[i];
				// A change counts only once two later stages agree.
				if (s2_q[i] == s3_q[i]) begin
					level_out[i] <= s3_q[i];
				end
			end
		end
	end
endmodule

//--- hw/sbsd_decode.sv
// Cycle type and byte lane decode of a captured host request.
`timescale 1ns/1ps
module sbsd_decode (
	// Captured request fields.
	input  wire logic [1:0]  region_in,
	input  wire logic [1:0]  tm_in,
	input  wire logic [1:0]  low_in,
	// Decoded cycle.
	output sbsd_pkg::sbsd_kind_e kind_out,
	output logic      [1:0]  lanes_out
);
	always_comb begin
		kind_out  = sbsd_pkg::kind_err;
		lanes_out = sbsd_pkg::LANE_NONE;
		unique case (region_in)
			sbsd_pkg::REGION_RAM: begin
				if (!tm_in[1]) begin
					kind_out = sbsd_pkg::kind_ram_rd;
				end else begin
					kind_out = sbsd_pkg::kind_ram_wr;
					// An odd half-word address writes nothing.
					if (!low_in[1]) begin
						if (!tm_in[0]) begin
							lanes_out = sbsd_pkg::LANE_BOTH;
						end else if (low_in[0]) begin
							lanes_out = sbsd_pkg::LANE_B1;
						end else begin
							lanes_out = sbsd_pkg::LANE_B0;
						end
					end
				end
			end
			sbsd_pkg::REGION_ROM: begin
				if (tm_in[1]) begin
					kind_out = sbsd_pkg::kind_err;
				end else begin
					kind_out = sbsd_pkg::kind_rom_rd;
				end
			end
			sbsd_pkg::REGION_PC: begin
				if (tm_in[0]) begin
					kind_out = sbsd_pkg::kind_pc_wr;
				end else begin
					kind_out = sbsd_pkg::kind_pc_rd;
				end
			end
			sbsd_pkg::REGION_NONE: begin
				kind_out = sbsd_pkg::kind_err;
			end
		endcase
	end
endmodule

//--- hw/sbsd_slave.sv
// Slot bus slave: address match, decode, local access and acknowledge.
`timescale 1ns/1ps

module sbsd_slave (
	// Clock, reset and clock enable.
	input  wire logic              clock_in,
	input  wire logic              rst_n_in,
	input  wire logic              ce_in,
	// Host bus inputs, logic high means asserted.
	input  wire logic              bus_clk_in,
	input  wire logic              start_in,
	input  wire logic [1:0]        tm_in,
	input  wire logic [31:0]       ad_in,
	input  wire logic [3:0]        slot_id_in,
	// Host bus drivers.
	output logic      [31:0]       ad_out,
	output logic                   ad_oe_out,
	output logic      [1:0]        tm_out,
	output logic                   tm_oe_out,
	output logic                   ack_out,
	output logic                   ack_oe_out,
	// Local bus shared with the packet controller.
	output logic      [13:0]       loc_addr_out,
	output logic      [15:0]       loc_wdata_out,
	output logic                   loc_rd_out,
	output logic      [1:0]        loc_we_out,
	output logic                   ram_cs_out,
	output logic                   rom_cs_out,
	output logic                   pc_cs_out,
	input  wire logic [15:0]       ram_rdata_in,
	input  wire logic [7:0]        rom_rdata_in,
	input  wire logic [7:0]        pc_rdata_in,
	// Packet controller arbitration.
	input  wire logic              pc_req_in,
	output logic                   pc_gnt_out
);
	typedef enum logic [2:0] {
		idle_state,
		pc_own_state,
		decode_state,
		wdata_state,
		access_state,
		wait_state,
		ack_state
	} sbsd_state_e;

	sbsd_state_e st_q;

	logic [sbsd_pkg::SYNC_W-1:0] sync_lvl;
	logic                        bclk;
	logic                        bstart;
	logic [1:0]                  btm;
	logic [31:0]                 bad;
	logic [3:0]                  bid;
	logic                        bclk_prev_q;
	logic                        bus_rise;
	logic                        bus_fall;
	logic                        slot_hit;

	logic                        pend_q;
	logic [31:0]                 addr_q;
	logic [1:0]                  tmreq_q;
	logic [15:0]                 wdata_q;
	logic [1:0]                  status_q;
	logic [31:0]                 rdata_q;
	logic [1:0]                  acc_cnt_q;
	logic [3:0]                  cyc_cnt_q;
	logic                        wd_expired;
	logic                        is_read;
	logic                        is_write;
	logic                        go_access;
	logic                        take_req;

	sbsd_pkg::sbsd_kind_e        kind;
	logic [1:0]                  lanes;

	sbsd_sync #(
		.W(sbsd_pkg::SYNC_W)
	) u_sync (
		.clock_in  (clock_in),
		.rst_n_in  (rst_n_in),
		.ce_in     (ce_in),
		.raw_in    ({bus_clk_in, start_in, tm_in, ad_in, slot_id_in}),
		.level_out (sync_lvl)
	);

	assign {bclk, bstart, btm, bad, bid} = sync_lvl;

	// Only the filtered bus clock is used, so edges follow the bus by a fixed lag.
	assign bus_rise = bclk & ~bclk_prev_q;
	assign bus_fall = ~bclk & bclk_prev_q;

	// The upper nibble is the top super slot, the lower one the geographic identity.
	assign slot_hit = (bad[sbsd_pkg::SLOT_HI:sbsd_pkg::SLOT_LO] == {sbsd_pkg::SUPER_SLOT, bid});

	sbsd_decode u_decode (
		.region_in (addr_q[sbsd_pkg::DEV_HI:sbsd_pkg::DEV_LO]),
		.tm_in     (tmreq_q),
		.low_in    (addr_q[1:0]),
		.kind_out  (kind),
		.lanes_out (lanes)
	);

	assign is_read = (kind == sbsd_pkg::kind_ram_rd) || (kind == sbsd_pkg::kind_rom_rd)
		|| (kind == sbsd_pkg::kind_pc_rd);
	assign is_write = (kind == sbsd_pkg::kind_ram_wr) || (kind == sbsd_pkg::kind_pc_wr);
	assign wd_expired = (cyc_cnt_q >= sbsd_pkg::MAX_CYCLES);
	assign take_req = (st_q == idle_state) && !pc_req_in && pend_q;
	assign go_access = ((st_q == decode_state) && is_read)
		|| ((st_q == wdata_state) && bus_fall && !wd_expired);

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			bclk_prev_q <= 1'b0;
		end else if (ce_in) begin
			bclk_prev_q <= bclk;
		end
	end

	// Request capture. A start seen while busy is held until the sequencer is idle.
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pend_q  <= 1'b0;
			addr_q  <= 32'h0000_0000;
			tmreq_q <= 2'h0;
		end else if (ce_in) begin
			if (bus_fall && bstart && slot_hit && !pend_q) begin
				pend_q  <= 1'b1;
				addr_q  <= bad;
				tmreq_q <= btm;
			end else if (take_req) begin
				pend_q <= 1'b0;
			end
		end
	end

	// Sequencer.
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_q <= idle_state;
		end else if (ce_in) begin
			unique case (st_q)
				idle_state: begin
					if (pc_req_in) begin
						st_q <= pc_own_state;
					end else if (pend_q) begin
						st_q <= decode_state;
					end
				end
				pc_own_state: begin
					if (!pc_req_in) begin
						st_q <= idle_state;
					end
				end
				decode_state: begin
					if (is_read) begin
						st_q <= access_state;
					end else if (is_write) begin
						st_q <= wdata_state;
					end else begin
						st_q <= wait_state;
					end
				end
				wdata_state: begin
					if (wd_expired) begin
						st_q <= wait_state;
					end else if (bus_fall) begin
						st_q <= access_state;
					end
				end
				access_state: begin
					if (acc_cnt_q == sbsd_pkg::ACC_ONE) begin
						st_q <= wait_state;
					end
				end
				wait_state: begin
					if (bus_rise) begin
						st_q <= ack_state;
					end
				end
				ack_state: begin
					if (bus_rise) begin
						st_q <= idle_state;
					end
				end
			endcase
		end
	end

	// Cycle length guard and local access counter.
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cyc_cnt_q <= sbsd_pkg::CNT_ZERO;
			acc_cnt_q <= sbsd_pkg::ACC_ZERO;
		end else if (ce_in) begin
			if (st_q == idle_state) begin
				cyc_cnt_q <= sbsd_pkg::CNT_ZERO;
			end else if (!wd_expired) begin
				cyc_cnt_q <= cyc_cnt_q + sbsd_pkg::CNT_ONE;
			end
			if (go_access) begin
				acc_cnt_q <= sbsd_pkg::LOC_WAIT;
			end else if (acc_cnt_q != sbsd_pkg::ACC_ZERO) begin
				acc_cnt_q <= acc_cnt_q - sbsd_pkg::ACC_ONE;
			end
		end
	end

	// Write data and status.
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wdata_q  <= 16'h0000;
			status_q <= sbsd_pkg::TM_COMPLETE;
		end else if (ce_in) begin
			if ((st_q == wdata_state) && bus_fall) begin
				wdata_q <= bad[15:0];
			end
			if (st_q == decode_state) begin
				if (kind == sbsd_pkg::kind_err) begin
					status_q <= sbsd_pkg::TM_BUSERR;
				end else begin
					status_q <= sbsd_pkg::TM_COMPLETE;
				end
			end else if ((st_q == wdata_state) && wd_expired) begin
				// A write whose data never came cannot complete, so it is refused.
				status_q <= sbsd_pkg::TM_BUSERR;
			end
		end
	end

	// Local bus strobes, held for the local access.
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			loc_addr_out  <= 14'h0000;
			loc_wdata_out <= 16'h0000;
			loc_rd_out    <= 1'b0;
			loc_we_out    <= sbsd_pkg::LANE_NONE;
			ram_cs_out    <= 1'b0;
			rom_cs_out    <= 1'b0;
			pc_cs_out     <= 1'b0;
		end else if (ce_in) begin
			if (go_access) begin
				loc_addr_out  <= addr_q[sbsd_pkg::LOC_HI:sbsd_pkg::LOC_LO];
				loc_wdata_out <= ((st_q == wdata_state) && bus_fall) ? bad[15:0] : wdata_q;
				loc_rd_out    <= is_read;
				ram_cs_out    <= (kind == sbsd_pkg::kind_ram_rd) || (kind == sbsd_pkg::kind_ram_wr);
				rom_cs_out    <= (kind == sbsd_pkg::kind_rom_rd);
				pc_cs_out     <= (kind == sbsd_pkg::kind_pc_rd) || (kind == sbsd_pkg::kind_pc_wr);
				if (kind == sbsd_pkg::kind_ram_wr) begin
					loc_we_out <= lanes;
				end else if (kind == sbsd_pkg::kind_pc_wr) begin
					loc_we_out <= sbsd_pkg::LANE_B0;
				end else begin
					loc_we_out <= sbsd_pkg::LANE_NONE;
				end
			end else if ((st_q == access_state) && (acc_cnt_q == sbsd_pkg::ACC_ONE)) begin
				loc_rd_out <= 1'b0;
				loc_we_out <= sbsd_pkg::LANE_NONE;
				ram_cs_out <= 1'b0;
				rom_cs_out <= 1'b0;
				pc_cs_out  <= 1'b0;
			end
		end
	end

	// Read data capture at the end of the local access.
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_q <= 32'h0000_0000;
		end else if (ce_in) begin
			if ((st_q == access_state) && (acc_cnt_q == sbsd_pkg::ACC_ONE) && loc_rd_out) begin
				if (ram_cs_out) begin
					rdata_q <= {16'h0000, ram_rdata_in};
				end else if (rom_cs_out) begin
					rdata_q <= {24'h00_0000, rom_rdata_in};
				end else begin
					rdata_q <= {24'h00_0000, pc_rdata_in};
				end
			end
		end
	end

	// Bus drivers: acknowledge, status and read data rise and fall together.
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ad_out     <= 32'h0000_0000;
			ad_oe_out  <= 1'b0;
			tm_out     <= sbsd_pkg::TM_IDLE;
			tm_oe_out  <= 1'b0;
			ack_out    <= 1'b0;
			ack_oe_out <= 1'b0;
		end else if (ce_in) begin
			if ((st_q == wait_state) && bus_rise) begin
				ack_out    <= 1'b1;
				ack_oe_out <= 1'b1;
				tm_out     <= status_q;
				tm_oe_out  <= 1'b1;
				ad_out     <= rdata_q;
				ad_oe_out  <= is_read && (status_q == sbsd_pkg::TM_COMPLETE);
			end else if ((st_q == ack_state) && bus_rise) begin
				ack_out    <= 1'b0;
				ack_oe_out <= 1'b0;
				tm_out     <= sbsd_pkg::TM_IDLE;
				tm_oe_out  <= 1'b0;
				ad_oe_out  <= 1'b0;
			end
		end
	end

	// Grant follows the sequencer so no host cycle is ever cut short.
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pc_gnt_out <= 1'b0;
		end else if (ce_in) begin
			pc_gnt_out <= ((st_q == idle_state) && pc_req_in)
				|| ((st_q == pc_own_state) && pc_req_in);
		end
	end
endmodule

//--- tb/sbsd_slave_chk.sv
// Port checker for the slot bus slave.
`timescale 1ns/1ps
module sbsd_slave_chk (
	input wire logic        clock_in,
	input wire logic        rst_n_in,
	input wire logic        start_in,
	input wire logic [31:0] ad_in,
	input wire logic [3:0]  slot_id_in,
	input wire logic        pc_req_in,
	input wire logic        ad_oe_out,
	input wire logic [1:0]  tm_out,
	input wire logic        tm_oe_out,
	input wire logic        ack_out,
	input wire logic        ack_oe_out,
	input wire logic [1:0]  loc_we_out,
	input wire logic        ram_cs_out,
	input wire logic        rom_cs_out,
	input wire logic        pc_cs_out,
	input wire logic        pc_gnt_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);
	logic hit;
	logic cs_any;
	assign hit    = ad_in[31:24] == {sbsd_pkg::SUPER_SLOT, slot_id_in};
	assign cs_any = ram_cs_out | rom_cs_out | pc_cs_out;
	ack_pair_a: assert property (ack_oe_out |-> ack_out && tm_oe_out)
		else $error("ack without status drive");
	status_code_a: assert property (tm_oe_out |-> tm_out == sbsd_pkg::TM_COMPLETE
		|| tm_out == sbsd_pkg::TM_BUSERR) else $error("illegal status code");
	ack_width_a: assert property ($rose(ack_oe_out) |-> ack_oe_out[*8] ##[1:6]
		!ack_oe_out) else $error("ack not one bus clock long");
	data_with_ack_a: assert property (ad_oe_out |-> ack_oe_out
		&& tm_out == sbsd_pkg::TM_COMPLETE) else $error("data driven outside good ack");
	data_rise_a: assert property ($rose(ad_oe_out) |-> $rose(ack_oe_out))
		else $error("data and ack not launched together");
	error_quiet_a: assert property (tm_oe_out && tm_out == sbsd_pkg::TM_BUSERR
		|-> !cs_any) else $error("device selected during bus error");
	rom_no_write_a: assert property (rom_cs_out |-> loc_we_out == sbsd_pkg::LANE_NONE)
		else $error("write enable on rom");
	grant_excl_a: assert property (pc_gnt_out |-> !cs_any)
		else $error("host access while controller owns bus");
	ack_bound_a: assert property ($rose(start_in) && hit && !pc_req_in && !pc_gnt_out
		|-> ##[1:60] ack_oe_out) else $error("cycle longer than five bus clocks");
	foreign_slot_a: assert property ($rose(start_in) && !hit && !ack_oe_out
		|-> !ack_oe_out[*8]) else $error("answered foreign slot");
	reset_idle_a: assert property ($rose(rst_n_in) |-> !ad_oe_out && !tm_oe_out
		&& !ack_oe_out) else $error("drivers enabled after reset");
	cover property ($rose(ack_oe_out) && tm_out == sbsd_pkg::TM_BUSERR);
	cover property ($rose(ack_oe_out) && tm_out == sbsd_pkg::TM_COMPLETE && !ad_oe_out);
	cover property ($rose(ad_oe_out));
	cover property ($rose(pc_gnt_out));
endmodule

//--- tb/sbsd_host_model.sv
// Host bus master model: slowed bus clock, single-word cycles, line release.
`timescale 1ns/1ps
module sbsd_host_model (
	// Clock.
	input  wire logic        clock_in,
	// Slave drivers.
	input  wire logic [31:0] slv_ad_in,
	input  wire logic        slv_ad_oe_in,
	input  wire logic [1:0]  slv_tm_in,
	input  wire logic        slv_tm_oe_in,
	input  wire logic        slv_ack_in,
	input  wire logic        slv_ack_oe_in,
	// Resolved bus lines.
	output logic             bus_clk_out,
	output logic             start_out,
	output logic      [1:0]  tm_out,
	output logic      [31:0] ad_out
);
	logic [3:0]  bcnt_q  = 4'h0;
	logic [31:0] m_ad    = 32'h0;
	logic [1:0]  m_tm    = 2'h0;
	logic        m_ad_oe = 1'b0;
	logic        m_tm_oe = 1'b0;
	initial start_out = 1'b0;
	// Six high and four low clocks, since a real 25 ns low phase slips past the filter.
	always @(posedge clock_in) begin
		#1;
		bcnt_q = (bcnt_q == 4'h9) ? 4'h0 : bcnt_q + 4'h1;
		bus_clk_out = bcnt_q < 4'h6;
	end
	// Released lines show the inverse of their last value, never a stale copy.
	assign ad_out = slv_ad_oe_in ? slv_ad_in : (m_ad_oe ? m_ad : ~m_ad);
	assign tm_out = slv_tm_oe_in ? slv_tm_in : (m_tm_oe ? m_tm : ~m_tm);
	// One single-word cycle; n counts bus clocks after the start clock.
	task automatic cycle(input logic [31:0] a, input logic [1:0] m, input logic w,
		input logic [31:0] d, output logic [1:0] s, output logic [31:0] r, output int n);
		n = 0;
		s = 2'h0;
		r = 32'h0;
		@(posedge bus_clk_out);
		start_out = 1'b1;
		m_ad = a;
		m_tm = m;
		m_ad_oe = 1'b1;
		m_tm_oe = 1'b1;
		@(posedge bus_clk_out);
		start_out = 1'b0;
		m_tm_oe = 1'b0;
		m_ad_oe = w;
		if (w) begin
			m_ad = d;
		end
		while (n < 8 && s == 2'h0) begin
			n++;
			@(negedge bus_clk_out);
			if (slv_ack_oe_in === 1'b1 && slv_ack_in === 1'b1) begin
				s = tm_out;
				r = ad_out;
			end
		end
		@(posedge bus_clk_out);
		m_ad_oe = 1'b0;
	endtask
endmodule

//--- tb/slot_bus_slave_decode_tb_top.sv
// Self-checking bench of the slot bus slave with a host master model.
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin fails++; \
	$display("unexpected at %0t got %0h expected %0h", $time, got, exp); end end
module slot_bus_slave_decode_tb_top;
	localparam logic [3:0] SLOT = 4'h9;
	localparam logic [1:0] OK   = sbsd_pkg::TM_COMPLETE;
	localparam logic [1:0] ERR  = sbsd_pkg::TM_BUSERR;
	int          fails = 0;
	int          samples_checked = 0;
	logic        clock_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic        pc_req_in = 1'b0;
	logic        bus_clk_in, start_in, ad_oe_out, tm_oe_out, ack_out, ack_oe_out;
	logic        loc_rd_out, ram_cs_out, rom_cs_out, pc_cs_out, pc_gnt_out;
	logic [1:0]  tm_in, tm_out, loc_we_out;
	logic [31:0] ad_in, ad_out;
	logic [13:0] loc_addr_out;
	logic [15:0] loc_wdata_out, ram_rdata_in;
	logic [7:0]  rom_rdata_in, pc_rdata_in;
	logic [15:0] ram [0:15];
	logic [7:0]  pc_reg = 8'h00;
	always #20 clock_in = ~clock_in;
	initial foreach (ram[i]) ram[i] = 16'h0000;
	// Read data shows only under the read strobe, so a missing strobe reads as zero.
	assign ram_rdata_in = loc_rd_out ? ram[loc_addr_out[3:0]] : 16'h0000;
	assign rom_rdata_in = loc_rd_out ? (loc_addr_out[7:0] ^ 8'hA5) : 8'h00;
	assign pc_rdata_in  = loc_rd_out ? pc_reg : 8'h00;
	always @(posedge clock_in) begin
		if (ram_cs_out && loc_we_out[0]) ram[loc_addr_out[3:0]][7:0] <= loc_wdata_out[7:0];
		if (ram_cs_out && loc_we_out[1]) ram[loc_addr_out[3:0]][15:8] <= loc_wdata_out[15:8];
		if (pc_cs_out && loc_we_out[0]) pc_reg <= loc_wdata_out[7:0];
	end
	sbsd_host_model host (.clock_in, .slv_ad_in(ad_out), .slv_ad_oe_in(ad_oe_out),
		.slv_tm_in(tm_out), .slv_tm_oe_in(tm_oe_out), .slv_ack_in(ack_out),
		.slv_ack_oe_in(ack_oe_out), .bus_clk_out(bus_clk_in), .start_out(start_in),
		.tm_out(tm_in), .ad_out(ad_in));
	sbsd_slave dut (.clock_in, .rst_n_in, .ce_in(1'b1), .bus_clk_in, .start_in, .tm_in,
		.ad_in, .slot_id_in(SLOT), .ad_out, .ad_oe_out, .tm_out, .tm_oe_out, .ack_out,
		.ack_oe_out, .loc_addr_out, .loc_wdata_out, .loc_rd_out, .loc_we_out, .ram_cs_out,
		.rom_cs_out, .pc_cs_out, .ram_rdata_in, .rom_rdata_in, .pc_rdata_in, .pc_req_in,
		.pc_gnt_out);
	function automatic logic [31:0] mk(input logic [1:0] dv, input logic [13:0] l,
		input logic [1:0] lo, input logic [3:0] hi);
		return {sbsd_pkg::SUPER_SLOT, SLOT, hi, dv, 2'h0, l, lo};
	endfunction
	task automatic go(input logic [31:0] a, input logic [1:0] m, input logic w,
		input logic [31:0] d, input logic [1:0] es, input logic [31:0] ed);
		logic [1:0]  s;
		logic [31:0] r;
		int          n;
		host.cycle(a, m, w, d, s, r, n);
		`CHK(s, es)
		if (!w && es == OK) `CHK(r, ed)
		if (es != sbsd_pkg::TM_IDLE) `CHK(n <= 4, 1'b1)
	endtask
	task automatic t_reset_idle;
		repeat (2) @(posedge clock_in);
		#1;
		`CHK({ad_oe_out, tm_oe_out, ack_oe_out, pc_gnt_out}, 4'h0)
		@(posedge clock_in);
		#1 rst_n_in = 1'b1;
		repeat (6) @(posedge clock_in);
		#1;
		`CHK({ad_oe_out, tm_oe_out, ack_oe_out, pc_gnt_out}, 4'h0)
		$display("test reset_idle done");
	endtask
	task automatic t_ram_lanes;
		go(mk(2'h1, 14'h0003, 2'h0, 4'h0), 2'h2, 1'b1, 32'h0000_1234, OK, 32'h0);
		go(mk(2'h1, 14'h0003, 2'h0, 4'h7), 2'h0, 1'b0, 32'h0, OK, 32'h0000_1234);
		go(mk(2'h1, 14'h0003, 2'h0, 4'h0), 2'h3, 1'b1, 32'h0000_AB56, OK, 32'h0);
		go(mk(2'h1, 14'h0003, 2'h1, 4'h0), 2'h3, 1'b1, 32'h0000_CD78, OK, 32'h0);
		go(mk(2'h1, 14'h0003, 2'h2, 4'h0), 2'h2, 1'b1, 32'h0000_FFFF, OK, 32'h0);
		go(mk(2'h1, 14'h0003, 2'h3, 4'h0), 2'h1, 1'b0, 32'h0, OK, 32'h0000_CD56);
		go(mk(2'h1, 14'h0004, 2'h0, 4'h0), 2'h0, 1'b0, 32'h0, OK, 32'h0000_0000);
		$display("test ram_lanes done");
	endtask
	task automatic t_rom_and_ctrl;
		go(mk(2'h3, 14'h0012, 2'h0, 4'h0), 2'h0, 1'b0, 32'h0, OK, 32'h0000_00B7);
		go(mk(2'h3, 14'h0012, 2'h0, 4'h0), 2'h2, 1'b1, 32'h0000_5555, ERR, 32'h0);
		go(mk(2'h2, 14'h0005, 2'h0, 4'h0), 2'h1, 1'b1, 32'h0000_003C, OK, 32'h0);
		go(mk(2'h2, 14'h0005, 2'h0, 4'h0), 2'h0, 1'b0, 32'h0, OK, 32'h0000_003C);
		$display("test rom_and_ctrl done");
	endtask
	task automatic t_refusals;
		go(mk(2'h0, 14'h0001, 2'h0, 4'h0), 2'h0, 1'b0, 32'h0, ERR, 32'h0);
		go(mk(2'h0, 14'h0001, 2'h0, 4'h0), 2'h2, 1'b1, 32'h0000_1111, ERR, 32'h0);
		go({8'hF3, 24'h04_0000}, 2'h0, 1'b0, 32'h0, sbsd_pkg::TM_IDLE, 32'h0);
		$display("test refusals done");
	endtask
	task automatic t_ctrl_priority;
		@(posedge clock_in);
		#1 pc_req_in = 1'b1;
		repeat (3) @(posedge clock_in);
		#1;
		`CHK(pc_gnt_out, 1'b1)
		pc_req_in = 1'b0;
		repeat (3) @(posedge clock_in);
		#1;
		`CHK(pc_gnt_out, 1'b0)
		go(mk(2'h1, 14'h0003, 2'h0, 4'h0), 2'h0, 1'b0, 32'h0, OK, 32'h0000_CD56);
		// The host cycle is taken while the controller owns the bus and must wait for it.
		pc_req_in = 1'b1;
		fork
			go(mk(2'h1, 14'h0003, 2'h0, 4'h0), 2'h0, 1'b0, 32'h0, OK, 32'h0000_CD56);
			begin
				@(posedge start_in);
				repeat (14) @(posedge clock_in);
				#1;
				`CHK({pc_gnt_out, ram_cs_out}, 2'h2)
				pc_req_in = 1'b0;
			end
		join
		$display("test ctrl_priority done");
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		#400000;
		fails++;
		end_of_test();
	end
	initial begin
		t_reset_idle();
		t_ram_lanes();
		t_rom_and_ctrl();
		t_refusals();
		t_ctrl_priority();
		end_of_test();
	end
endmodule
bind sbsd_slave sbsd_slave_chk chk (.clock_in, .rst_n_in, .start_in, .ad_in, .slot_id_in,
	.pc_req_in, .ad_oe_out, .tm_out, .tm_oe_out, .ack_out, .ack_oe_out, .loc_we_out,
	.ram_cs_out, .rom_cs_out, .pc_cs_out, .pc_gnt_out);
